// file: rtl/caf_filter_buffers.sv
// caf_filter_buffers: acceptance masking, rx full/overflow flags and tx buffer control
// assumes the protocol engine shares core_clk and drives one-cycle event pulses
// Notes on behaviour
// - masked extended bits must equal filter bits, on extended frames only
// - mask source 0,1,2 picks mask; 3 reserved
// - sixteen two-bit sources, eight per register
// - mask standard bit one compares, zero ignores
// - mask extended bits behave identically
// - type match on: frame type equals filter
// - type match off: either frame type accepted
// - three masks, standard and extended registers
// - storing a received message sets full flag
// - store into full buffer sets overflow
// - direction bit set means transmit buffer
// - aborted flag set on abort, cleared on successful send
// - lost arbitration sets its flag
// - bus error during send sets flag
// - send request rising clears outcome flags
// - request queues message, cleared on success
// - clearing pending request asks for abort
// - remote reply enable sets request on rtr
// - two-bit priority schedules pending messages
// - each control register serves two buffers
// - message contents live in shared RAM
// - pointer 15 means FIFO, else buffer
// - extended select one extended, zero standard
// - accepting filter number given as hit code
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module caf_filter_buffers
  import caf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxFrameValid,
  input wire caf_frame_t rxFrame,
  output logic acceptValid,
  output logic [4:0] acceptHitCode,
  output logic [3:0] acceptBufPtr,
  output logic acceptToFifo,
  input wire logic rxStoreValid,
  input wire logic [4:0] rxStoreBuf,
  input wire logic rtrHitValid,
  input wire logic [2:0] rtrHitBuf,
  input wire logic txResultValid,
  input wire caf_tx_result_t txResult,
  output logic txPendValid,
  output logic [2:0] txPendBuf,
  output logic [7:0] txAbortReq
);

  // configuration, status and answer registers; message bodies stay in shared RAM
  logic [31:0] maskSel_reg;
  logic [15:0] maskSid_reg [NUM_MASKS];
  logic [15:0] maskEid_reg [NUM_MASKS];
  logic [15:0] filtSid_reg [NUM_FILTERS];
  logic [15:0] filtEid_reg [NUM_FILTERS];
  logic [15:0] filtEn_reg;
  logic [63:0] bufPtr_reg;
  logic [31:0] rxFull_reg, rxFull_next;
  logic [31:0] rx_buffer_overflow_reg, rx_buffer_overflow_next;
  logic [63:0] bufCtrl_reg, bufCtrl_next;
  logic [7:0] abortReq_reg, abortReq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pslverr_reg, pslverr_next;
  logic acceptValid_reg;
  logic [4:0] acceptHit_reg;
  logic [3:0] acceptPtr_reg;
  logic acceptFifo_reg;
  logic txPendValid_reg, txPendValid_next;
  logic [2:0] txPendBuf_reg, txPendBuf_next;
  logic [NUM_FILTERS-1:0] filtHit;
  logic anyHit;
  logic [3:0] hitIdx;
  logic apbWr, apbRdPhase;
  logic addrAligned;
  logic [1:0] mskIdx, mskIdxE;

  // misaligned writes are refused like unmapped ones, so no register aliases a stray byte address
  assign addrAligned = paddr[1:0] == 2'h0;
  // one wait state: pready rises in the second access cycle
  assign apbWr = psel & penable & pready_reg & pwrite & addrAligned;
  assign apbRdPhase = psel & penable & ~pready_reg;
  assign mskIdx = 2'((paddr - ADDR_MSID0) >> 2);
  assign mskIdxE = 2'((paddr - ADDR_MEID0) >> 2);

  // per-filter comparison against the selected mask
  for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filt
    logic [1:0] sel;
    logic [15:0] mS, mE;
    logic [10:0] sidDiff;
    logic [17:0] eidDiff;
    logic typeOk, idOk;
    // ids and masks reset to zero: an enabled filter with a zero mask takes every frame
    assign sel = maskSel_reg[2*f +: 2];
    assign mS = (sel == MSEL_RESERVED) ? ZERO16 : maskSid_reg[sel];
    assign mE = (sel == MSEL_RESERVED) ? ZERO16 : maskEid_reg[sel];
    // the remote bit plays no part here; remote replies arrive as rtr hits
    assign sidDiff = (rxFrame.standard_id_bits ^ filtSid_reg[f][SID_HI:SID_LO]) & mS[SID_HI:SID_LO];
    assign eidDiff = (rxFrame.extended_id_bits ^ {filtSid_reg[f][EIDU_HI:0], filtEid_reg[f]})
                     & {mS[EIDU_HI:0], mE};
    // standard frames carry no extended bits, so only the standard part compares
    assign idOk = (sidDiff == 11'h000) & (~rxFrame.ext | (eidDiff == 18'h00000));
    assign typeOk = ~mS[ID_TYPE_BIT] | (rxFrame.ext == filtSid_reg[f][ID_TYPE_BIT]);
    // reserved mask source never matches rather than guessing a mask
    assign filtHit[f] = filtEn_reg[f] & (sel != MSEL_RESERVED) & typeOk & idOk;
  end

  // lowest numbered hitting filter wins
  always_comb begin
    anyHit = 1'b0;
    hitIdx = 4'h0;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (filtHit[i]) begin
        anyHit = 1'b1;
        hitIdx = 4'(i);
      end
    end
  end

  // acceptance result toward the store engine; message body goes to shared RAM
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      acceptValid_reg <= 1'b0;
      acceptHit_reg <= 5'h00;
      acceptPtr_reg <= 4'h0;
      acceptFifo_reg <= 1'b0;
    end else begin
      acceptValid_reg <= rxFrameValid & anyHit;
      acceptHit_reg <= {1'b0, hitIdx};
      acceptPtr_reg <= bufPtr_reg[4*hitIdx +: 4];
      acceptFifo_reg <= bufPtr_reg[4*hitIdx +: 4] == BPTR_FIFO;
    end
  end

  // plain configuration registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      maskSel_reg <= {ZERO16, ZERO16};
      filtEn_reg <= FEN_RST;
      bufPtr_reg <= {ZERO16, ZERO16, ZERO16, ZERO16};
      for (int m = 0; m < NUM_MASKS; m++) begin
        maskSid_reg[m] <= ZERO16;
        maskEid_reg[m] <= ZERO16;
      end
      for (int f = 0; f < NUM_FILTERS; f++) begin
        filtSid_reg[f] <= ZERO16;
        filtEid_reg[f] <= ZERO16;
      end
    end else if (apbWr) begin
      if (paddr == ADDR_MSEL_LO) maskSel_reg[15:0] <= pwdata[15:0];
      if (paddr == ADDR_MSEL_HI) maskSel_reg[31:16] <= pwdata[15:0];
      if (paddr == ADDR_FEN) filtEn_reg <= pwdata[15:0];
      for (int k = 0; k < 4; k++) begin
        if (paddr == ADDR_BPTR0 + 8'(4*k)) bufPtr_reg[16*k +: 16] <= pwdata[15:0];
      end
      if (paddr >= ADDR_MSID0 && paddr < ADDR_MEID0) maskSid_reg[mskIdx] <= pwdata[15:0] & SIDREG_WMASK;
      if (paddr >= ADDR_MEID0 && paddr < ADDR_FULL_LO) maskEid_reg[mskIdxE] <= pwdata[15:0];
      if (paddr[7:6] == PAGE_FSID) filtSid_reg[paddr[5:2]] <= pwdata[15:0] & SIDREG_WMASK;
      if (paddr[7:6] == PAGE_FEID) filtEid_reg[paddr[5:2]] <= pwdata[15:0];
    end
  end

  // full and overflow flags: hardware set wins over a same-cycle software clear
  always_comb begin
    rxFull_next = rxFull_reg;
    rx_buffer_overflow_next = rx_buffer_overflow_reg;
    if (apbWr && paddr == ADDR_FULL_LO) rxFull_next[15:0] = rxFull_reg[15:0] & pwdata[15:0];
    if (apbWr && paddr == ADDR_FULL_HI) rxFull_next[31:16] = rxFull_reg[31:16] & pwdata[15:0];
    if (apbWr && paddr == ADDR_OVF_LO) rx_buffer_overflow_next[15:0] = rx_buffer_overflow_reg[15:0] & pwdata[15:0];
    if (apbWr && paddr == ADDR_OVF_HI) rx_buffer_overflow_next[31:16] = rx_buffer_overflow_reg[31:16] & pwdata[15:0];
    if (rxStoreValid) begin
      // old full bit decides, so a clear in the same cycle still reports the loss
      if (rxFull_reg[rxStoreBuf]) rx_buffer_overflow_next[rxStoreBuf] = 1'h1;
      rxFull_next[rxStoreBuf] = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rxFull_reg <= {ZERO16, ZERO16};
      rx_buffer_overflow_reg <= {ZERO16, ZERO16};
    end else begin
      rxFull_reg <= rxFull_next;
      rx_buffer_overflow_reg <= rx_buffer_overflow_next;
    end
  end

  // per-buffer control byte, two buffers per register
  always_comb begin
    logic [7:0] cur, nxt, wb;
    logic wr, reqSet, reqClr, mine;
    cur = 8'h00;
    nxt = 8'h00;
    wb = 8'h00;
    wr = 1'b0;
    reqSet = 1'b0;
    reqClr = 1'b0;
    mine = 1'b0;
    bufCtrl_next = bufCtrl_reg;
    abortReq_next = abortReq_reg;
    for (int b = 0; b < NUM_TX_BUFS; b++) begin
      cur = bufCtrl_reg[8*b +: 8];
      nxt = cur;
      wr = apbWr && paddr == ADDR_CTRL0 + 8'(4*(b/2));
      wb = pwdata[8*(b%2) +: 8];
      mine = txResultValid && txResult.bufIdx == 3'(b);
      // status bits are read-only; only direction, request, reply enable, priority take writes
      if (wr) nxt = (cur & ~CTL_WMASK) | (wb & CTL_WMASK);
      // only a written zero over a set request counts as an abort
      reqClr = wr & cur[CTL_REQ] & ~wb[CTL_REQ];
      reqSet = (wr & wb[CTL_REQ]) | (rtrHitValid && rtrHitBuf == 3'(b) && cur[CTL_RTR]);
      if (mine && txResult.sent) nxt[CTL_REQ] = 1'b0;
      if (reqSet) nxt[CTL_REQ] = 1'b1;
      else if (reqClr) nxt[CTL_REQ] = 1'b0;
      if (mine) begin
        if (txResult.aborted) nxt[CTL_ABT] = 1'b1;
        if (txResult.sent) nxt[CTL_ABT] = 1'b0;
        if (txResult.lostArb) nxt[CTL_LARB] = 1'b1;
        if (txResult.busErr) nxt[CTL_ERR] = 1'b1;
      end
      // a fresh request starts with clean outcome flags
      if (nxt[CTL_REQ] & ~cur[CTL_REQ]) begin
        nxt[CTL_ABT] = 1'b0;
        nxt[CTL_LARB] = 1'b0;
        nxt[CTL_ERR] = 1'b0;
      end
      bufCtrl_next[8*b +: 8] = nxt;
      // abort request holds until the engine reports back or a new request supersedes it
      if (mine || reqSet) abortReq_next[b] = 1'b0;
      if (reqClr && !reqSet) abortReq_next[b] = 1'b1;
    end
  end

  // control bytes and abort requests
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bufCtrl_reg <= {ZERO16, ZERO16, ZERO16, ZERO16};
      abortReq_reg <= 8'h00;
    end else begin
      bufCtrl_reg <= bufCtrl_next;
      abortReq_reg <= abortReq_next;
    end
  end

  // pick highest priority pending transmit buffer, lowest index on a tie
  always_comb begin
    logic [1:0] bestPri;
    logic [7:0] c;
    bestPri = 2'h0;
    c = 8'h00;
    txPendValid_next = 1'b0;
    txPendBuf_next = 3'h0;
    for (int b = 0; b < NUM_TX_BUFS; b++) begin
      c = bufCtrl_reg[8*b +: 8];
      if (c[CTL_DIR] && c[CTL_REQ] && (!txPendValid_next || c[CTL_PRI +: 2] > bestPri)) begin
        txPendValid_next = 1'b1;
        txPendBuf_next = 3'(b);
        bestPri = c[CTL_PRI +: 2];
      end
    end
  end

  // pending choice registered, one cycle behind the control bytes
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txPendValid_reg <= 1'b0;
      txPendBuf_reg <= 3'h0;
    end else begin
      txPendValid_reg <= txPendValid_next;
      txPendBuf_reg <= txPendBuf_next;
    end
  end

  // read mux; unmapped addresses answer zero with an error
  always_comb begin
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    // alignment first, so the filter pages refuse stray byte addresses too
    if (!addrAligned) pslverr_next = 1'h1;
    else if (paddr[7:6] == PAGE_FSID) prdata_next[15:0] = filtSid_reg[paddr[5:2]];
    else if (paddr[7:6] == PAGE_FEID) prdata_next[15:0] = filtEid_reg[paddr[5:2]];
    else if (paddr >= ADDR_MSID0 && paddr < ADDR_MEID0) prdata_next[15:0] = maskSid_reg[mskIdx];
    else if (paddr >= ADDR_MEID0 && paddr < ADDR_FULL_LO) prdata_next[15:0] = maskEid_reg[mskIdxE];
    else if (paddr >= ADDR_CTRL0 && paddr < ADDR_FEN) prdata_next[15:0] = bufCtrl_reg[16*paddr[3:2] +: 16];
    else if (paddr >= ADDR_BPTR0 && paddr < ADDR_BPTR0 + 8'h10) begin
      prdata_next[15:0] = bufPtr_reg[16*(2'((paddr - ADDR_BPTR0) >> 2)) +: 16];
    end else begin
      case (paddr)
        ADDR_MSEL_LO: prdata_next[15:0] = maskSel_reg[15:0];
        ADDR_MSEL_HI: prdata_next[15:0] = maskSel_reg[31:16];
        ADDR_FULL_LO: prdata_next[15:0] = rxFull_reg[15:0];
        ADDR_FULL_HI: prdata_next[15:0] = rxFull_reg[31:16];
        ADDR_OVF_LO: prdata_next[15:0] = rx_buffer_overflow_reg[15:0];
        ADDR_OVF_HI: prdata_next[15:0] = rx_buffer_overflow_reg[31:16];
        ADDR_FEN: prdata_next[15:0] = filtEn_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  // apb answer: data and error latched on the same edge that raises pready
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apbRdPhase;
      if (apbRdPhase) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
        pslverr_reg <= pslverr_next;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // every output straight from its flop; pslverr_reg is only ever high with pready
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign acceptValid = acceptValid_reg;
  assign acceptHitCode = acceptHit_reg;
  assign acceptBufPtr = acceptPtr_reg;
  assign acceptToFifo = acceptFifo_reg;
  assign txPendValid = txPendValid_reg;
  assign txPendBuf = txPendBuf_reg;
  assign txAbortReq = abortReq_reg;

endmodule : caf_filter_buffers

// file: rtl/caf_pkg.sv
// caf_pkg: shared constants and carriers for the acceptance filter and buffer control block
// assumes a 32-bit APB slave with byte addresses in an 8-bit window
package caf_pkg;
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int NUM_RX_BUFS = 32;
  localparam int NUM_TX_BUFS = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_MSEL_LO = 8'h00;
  localparam logic [7:0] ADDR_MSEL_HI = 8'h04;
  localparam logic [7:0] ADDR_MSID0 = 8'h08;
  localparam logic [7:0] ADDR_MEID0 = 8'h14;
  localparam logic [7:0] ADDR_FULL_LO = 8'h20;
  localparam logic [7:0] ADDR_FULL_HI = 8'h24;
  localparam logic [7:0] ADDR_OVF_LO = 8'h28;
  localparam logic [7:0] ADDR_OVF_HI = 8'h2C;
  localparam logic [7:0] ADDR_CTRL0 = 8'h30;
  localparam logic [7:0] ADDR_FEN = 8'h40;
  localparam logic [7:0] ADDR_BPTR0 = 8'h44;
  localparam logic [1:0] PAGE_FSID = 2'h2;
  localparam logic [1:0] PAGE_FEID = 2'h3;
  // identifier register layout
  localparam int SID_HI = 15;
  localparam int SID_LO = 5;
  localparam int ID_TYPE_BIT = 3;
  localparam int EIDU_HI = 1;
  localparam logic [15:0] SIDREG_WMASK = 16'hFFEB;
  // per-buffer control byte layout
  localparam int CTL_DIR = 7;
  localparam int CTL_ABT = 6;
  localparam int CTL_LARB = 5;
  localparam int CTL_ERR = 4;
  localparam int CTL_REQ = 3;
  localparam int CTL_RTR = 2;
  localparam int CTL_PRI = 0;
  localparam logic [7:0] CTL_WMASK = 8'h8F;
  // mask source and pointer codes
  localparam logic [1:0] MSEL_RESERVED = 2'h3;
  localparam logic [3:0] BPTR_FIFO = 4'hF;
  localparam logic [15:0] FEN_RST = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;

  typedef struct packed {
    logic ext;
    logic remote;
    logic [10:0] standard_id_bits;
    logic [17:0] extended_id_bits;
  } caf_frame_t;

  typedef struct packed {
    logic [2:0] bufIdx;
    logic sent;
    logic aborted;
    logic lostArb;
    logic busErr;
  } caf_tx_result_t;
endpackage : caf_pkg

// file: tb/caf_filter_buffers_props.sv
// caf_filter_buffers_props: port-level checks on the filter and buffer control block
// assumes one clock domain and the design's synchronous active-low reset
`timescale 1ns/1ps
module caf_filter_buffers_props
  import caf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxFrameValid,
  input wire logic acceptValid,
  input wire logic [4:0] acceptHitCode,
  input wire logic [3:0] acceptBufPtr,
  input wire logic acceptToFifo,
  input wire logic txResultValid,
  input wire caf_tx_result_t txResult,
  input wire logic txPendValid,
  input wire logic [2:0] txPendBuf,
  input wire logic [7:0] txAbortReq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // first access cycle of a transfer, and a successful send report
  sequence accStart;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence sentPulse;
    txResultValid && txResult.sent;
  endsequence

  // bus answer: one wait state, one-cycle strobe
  apb_wait_a: assert property (accStart |-> !pready ##1 pready) else $error("pready not in second access cycle");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  slverr_only_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_upper_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper read data not zero");
  // acceptance output tied to its frame
  accept_cause_a: assert property (acceptValid |-> $past(rxFrameValid)) else $error("accept without frame");
  fifo_steer_a: assert property (acceptValid |-> acceptToFifo == (acceptBufPtr == BPTR_FIFO))
    else $error("fifo flag disagrees with pointer");
  hit_range_a: assert property (acceptValid |-> !acceptHitCode[4]) else $error("hit code above filter 15");
  // transmit bookkeeping after an outcome report
  abort_drop_a: assert property (txResultValid |=> txAbortReq[$past(txResult.bufIdx)] == 1'h0)
    else $error("abort request kept after outcome");
  sent_clears_a: assert property (sentPulse |=> ##1 (!txPendValid || txPendBuf != $past(txResult.bufIdx, 2)))
    else $error("sent buffer still pending");
endmodule : caf_filter_buffers_props

bind caf_filter_buffers caf_filter_buffers_props i_caf_filter_buffers_props (.core_clk, .nrst, .psel, .penable,
  .prdata, .pready, .pslverr, .rxFrameValid, .acceptValid, .acceptHitCode, .acceptBufPtr, .acceptToFifo,
  .txResultValid, .txResult, .txPendValid, .txPendBuf, .txAbortReq);

// file: tb/caf_can_node.sv
// caf_can_node: stand-in for the bus and protocol engine feeding frames and events
// assumes callers space events; every pulse lasts exactly one cycle
`timescale 1ns/1ps
module caf_can_node
  import caf_pkg::*;
(
  input wire logic core_clk,
  output logic rxFrameValid,
  output caf_frame_t rxFrame,
  output logic rxStoreValid,
  output logic [4:0] rxStoreBuf,
  output logic rtrHitValid,
  output logic [2:0] rtrHitBuf,
  output logic txResultValid,
  output caf_tx_result_t txResult
);
  // quiet at time zero
  initial begin
    rxFrameValid = 1'h0;
    rxFrame = '0;
    rxStoreValid = 1'h0;
    rxStoreBuf = 5'h00;
    rtrHitValid = 1'h0;
    rtrHitBuf = 3'h0;
    txResultValid = 1'h0;
    txResult = '0;
  end
  // data inverted after each pulse so a stale value never looks valid
  task automatic frame(input caf_frame_t f);
    @(posedge core_clk);
    rxFrameValid <= 1'h1;
    rxFrame <= f;
    @(posedge core_clk);
    rxFrameValid <= 1'h0;
    rxFrame <= ~f;
  endtask : frame
  task automatic store(input logic [4:0] b);
    @(posedge core_clk);
    rxStoreValid <= 1'h1;
    rxStoreBuf <= b;
    @(posedge core_clk);
    rxStoreValid <= 1'h0;
    rxStoreBuf <= ~b;
  endtask : store
  task automatic rtr(input logic [2:0] b);
    @(posedge core_clk);
    rtrHitValid <= 1'h1;
    rtrHitBuf <= b;
    @(posedge core_clk);
    rtrHitValid <= 1'h0;
    rtrHitBuf <= ~b;
  endtask : rtr
  task automatic result(input caf_tx_result_t r);
    @(posedge core_clk);
    txResultValid <= 1'h1;
    txResult <= r;
    @(posedge core_clk);
    txResultValid <= 1'h0;
    txResult <= ~r;
  endtask : result
endmodule : caf_can_node

// file: tb/tb.sv
// tb: random and corner tests of acceptance filtering, rx flags and tx buffer control
// assumes one 40 MHz clock and an APB slave answering after one wait state
`timescale 1ns/1ps
module tb
  import caf_pkg::*;
;
  logic core_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, acceptValid, acceptToFifo, txPendValid, err, acc;
  logic [4:0] acceptHitCode, rxStoreBuf, b;
  logic [3:0] acceptBufPtr, nib;
  logic [2:0] txPendBuf, rtrHitBuf, best;
  logic [7:0] txAbortReq, pend, fa;
  logic rxFrameValid, rxStoreValid, rtrHitValid, txResultValid;
  caf_frame_t rxFrame, fr;
  caf_tx_result_t txResult;
  logic [15:0] ms [3], me [3], fs, fe, sel16, bp, fen, bit16;
  logic [1:0] sel, pri [8];
  logic [7:0] rstAddr [8] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h40};
  logic [4:0] corner [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
  int failures = 0, checked = 0, cyc = 0, seed = 82104, i, f, k;

  always #12.5 core_clk = ~core_clk;

  caf_filter_buffers i_caf_filter_buffers (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxFrameValid, .rxFrame, .acceptValid, .acceptHitCode, .acceptBufPtr, .acceptToFifo,
    .rxStoreValid, .rxStoreBuf, .rtrHitValid, .rtrHitBuf, .txResultValid, .txResult, .txPendValid, .txPendBuf,
    .txAbortReq);
  caf_can_node i_caf_can_node (.core_clk, .rxFrameValid, .rxFrame, .rxStoreValid, .rxStoreBuf, .rtrHitValid,
    .rtrHitBuf, .txResultValid, .txResult);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    // only the bench's cycle ceiling ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'h1, a, {16'h0000, d});
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, rdat, {16'h0000, exp});
  endtask : rchk
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle
  // expected acceptance of one filter under its selected mask
  function automatic logic hitf(logic [15:0] m1, m2, s1, s2, logic [1:0] sl, caf_frame_t x);
    logic [28:0] m = {m1[15:5], x.ext ? {m1[1:0], m2} : 18'h0};
    logic [28:0] d = {x.standard_id_bits ^ s1[15:5], x.extended_id_bits ^ {s1[1:0], s2}};
    if (sl == MSEL_RESERVED || (m1[3] && x.ext != s1[3])) return 1'h0;
    return (m & d) == 29'h0;
  endfunction : hitf
  // highest priority pending buffer, lowest index on a tie
  function automatic logic [2:0] pickf(logic [7:0] p, logic [1:0] pr [8]);
    logic [2:0] bb = 3'h0;
    logic found = 1'h0;
    for (int j = 0; j < 8; j++) begin
      if (p[j] && (!found || pr[j] > pr[bb])) begin
        bb = 3'(j);
        found = 1'h1;
      end
    end
    return bb;
  endfunction : pickf

  // hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    for (i = 0; i < 8; i++) rchk("reset", rstAddr[i], rstAddr[i] == ADDR_FEN ? FEN_RST : ZERO16);
    apb(1'h0, 8'h60, 32'h0);
    chk("unmapped", {err, rdat[30:0]}, 32'h80000000);
    wr(8'h02, 16'hFFFF);
    chk("misaligned", {31'h0, err}, 32'h1);
    wr({PAGE_FSID, 6'h01}, 16'hFFFF);
    chk("misaligned_page", {31'h0, err}, 32'h1);
    rchk("fsid_kept", {PAGE_FSID, 6'h00}, ZERO16);
    rchk("msel_kept", ADDR_MSEL_LO, ZERO16);
    // random filter setups, at most one filter enabled at a time
    for (i = 0; i < 48; i++) begin
      f = $random(seed) & 15;
      for (k = 0; k < 3; k++) begin
        ms[k] = 16'($random(seed) & $random(seed));
        me[k] = 16'($random(seed) & $random(seed));
        wr(ADDR_MSID0 + 8'(4 * k), ms[k]);
        wr(ADDR_MEID0 + 8'(4 * k), me[k]);
      end
      rchk("mask_rb", ADDR_MSID0 + 8'(4 * (i % 3)), ms[i % 3] & SIDREG_WMASK);
      fs = 16'($random(seed));
      fe = 16'($random(seed));
      sel16 = 16'($random(seed));
      bp = 16'($random(seed));
      if (i % 4 == 0) bp[4 * (f % 4) +: 4] = BPTR_FIFO;
      fen = (i % 8 == 7) ? ZERO16 : 16'h0001 << f;
      wr({PAGE_FSID, 4'(f), 2'h0}, fs);
      wr({PAGE_FEID, 4'(f), 2'h0}, fe);
      wr(f < 8 ? ADDR_MSEL_LO : ADDR_MSEL_HI, sel16);
      wr(ADDR_BPTR0 + 8'(4 * (f / 4)), bp);
      wr(ADDR_FEN, fen);
      sel = sel16[2 * (f % 8) +: 2];
      nib = bp[4 * (f % 4) +: 4];
      fr.ext = 1'($random(seed));
      fr.remote = 1'h0;
      fr.standard_id_bits = fs[15:5] ^ 11'($random(seed) & $random(seed) & $random(seed));
      fr.extended_id_bits = {fs[1:0], fe} ^ 18'($random(seed) & $random(seed) & $random(seed));
      acc = fen[f] && hitf(ms[sel % 3], me[sel % 3], fs, fe, sel, fr);
      i_caf_can_node.frame(fr);
      #1;
      chk("accept", {31'h0, acceptValid}, {31'h0, acc});
      if (acc) chk("steer", {22'h0, acceptHitCode, acceptBufPtr, acceptToFifo}, {22'h0, 5'(f), nib, nib == 4'hF});
    end
    // receive full and overflow flags at corner and random buffers
    for (k = 0; k < 6; k++) begin
      b = (k < 4) ? corner[k] : 5'($random(seed));
      fa = b < 16 ? ADDR_FULL_LO : ADDR_FULL_HI;
      bit16 = 16'h0001 << b[3:0];
      i_caf_can_node.store(b);
      rchk("full", fa, bit16);
      wr(fa, 16'hFFFF);
      rchk("full_w1", fa, bit16);
      i_caf_can_node.store(b);
      rchk("ovf", fa + 8'h08, bit16);
      wr(fa, ZERO16);
      wr(fa + 8'h08, ZERO16);
      rchk("full_clr", fa, ZERO16);
      rchk("ovf_clr", fa + 8'h08, ZERO16);
    end
    // all eight buffers queued with random priorities, sent in order
    for (k = 0; k < 8; k++) pri[k] = 2'($random(seed));
    for (k = 0; k < 4; k++) wr(ADDR_CTRL0 + 8'(4 * k), {6'h22, pri[2 * k + 1], 6'h22, pri[2 * k]});
    pend = 8'hFF;
    repeat (8) begin
      best = pickf(pend, pri);
      settle();
      chk("pend", {28'h0, txPendValid, txPendBuf}, {28'h0, 1'h1, best});
      i_caf_can_node.result({best, 4'h8});
      pend[best] = 1'h0;
    end
    settle();
    chk("idle", {31'h0, txPendValid}, 32'h0);
    for (k = 0; k < 4; k++) rchk("sent", ADDR_CTRL0 + 8'(4 * k), {6'h20, pri[2 * k + 1], 6'h20, pri[2 * k]});
    // abort of a pending request, then re-arm clears the outcome flags
    wr(ADDR_CTRL0, 16'h8888);
    wr(ADDR_CTRL0, 16'h8880);
    settle();
    chk("abort_req", {24'h0, txAbortReq}, 32'h01);
    i_caf_can_node.result({3'h0, 4'h7});
    rchk("outcome", ADDR_CTRL0, 16'h88F0);
    chk("abort_done", {24'h0, txAbortReq}, 32'h0);
    wr(ADDR_CTRL0, 16'h8888);
    rchk("rearm", ADDR_CTRL0, 16'h8888);
    // read-only flags ignored, remote reply only where enabled
    wr(ADDR_CTRL0 + 8'h04, 16'h80F4);
    rchk("ro_bits", ADDR_CTRL0 + 8'h04, 16'h8084);
    i_caf_can_node.rtr(3'h2);
    i_caf_can_node.rtr(3'h3);
    rchk("remote", ADDR_CTRL0 + 8'h04, 16'h808C);
    conclude();
  end
endmodule : tb
